/* File: design/cda_sync_pkg.sv */
package cda_sync_pkg;
	localparam int PAIRS = 4;
	localparam int BIT_IDX_W = 8;
	localparam int TSS_W = 5;
	localparam int DCL_PER_BIT = 2;
	localparam logic [7:0] SYNC_IRQ_STATUS_OFS = 8'h00;
	localparam logic [7:0] SYNC_IRQ_MASK_OFS = 8'h04;
	localparam logic [7:0] SYNC_IRQ_ACK_OFS = 8'h08;
	localparam logic [7:0] SLOT_ACCESS_CTRL_OFS = 8'h0c;
	localparam logic [7:0] SLOT_PORT_CONFIG_OFS = 8'h10;
	localparam logic [7:0] REG_STRIDE = 8'h04;
	localparam int XFER_LSB = 0;
	localparam int OVF_LSB = 4;
	localparam int IN_EN_LSB = 0;
	localparam int OUT_EN_LSB = 4;
	localparam int TSS_LSB = 0;
	localparam int PORT_SEL_BIT = 7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] SLOT_LAST_BIT = 8'h07;
	localparam logic [7:0] DELAY_PORT0 = 8'h02;
	localparam logic [7:0] DELAY_PORT1 = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: design/frame_bit_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module frame_bit_timer (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic double_rate_clock,
	input wire logic frame_sync,
	output logic frame_bit_clock,
	output logic [cda_sync_pkg::BIT_IDX_W-1:0] bit_index
);
	logic [1:0] dcl_sync_reg, dcl_sync_next;
	logic [1:0] fs_sync_reg, fs_sync_next;
	logic dcl_last_reg, dcl_last_next;
	logic fs_last_reg, fs_last_next;
	logic phase_reg, phase_next;
	logic frame_start_reg, frame_start_next;
	logic [cda_sync_pkg::BIT_IDX_W-1:0] index_reg, index_next;
	logic dcl_rise;
	logic tick;

	// Only the second synchroniser stage feeds the edge logic
	assign dcl_rise = dcl_sync_reg[1] & ~dcl_last_reg;
	assign tick = dcl_rise & phase_reg;

	always_comb begin
		dcl_sync_next = {dcl_sync_reg[0], double_rate_clock};
		fs_sync_next = {fs_sync_reg[0], frame_sync};
		dcl_last_next = dcl_sync_reg[1];
		fs_last_next = fs_sync_reg[1];
		phase_next = phase_reg;
		index_next = index_reg;
		frame_start_next = frame_start_reg;
		if (fs_sync_reg[1] & ~fs_last_reg) begin
			frame_start_next = 1'b1;
		end
		if (dcl_rise) begin
			phase_next = ~phase_reg;
			if (frame_start_reg & ~phase_reg) begin
				// First full bit of a frame is bit 0
				phase_next = 1'b1;
				index_next = '0;
				frame_start_next = 1'b0;
			end else if (phase_reg) begin
				index_next = index_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dcl_sync_reg <= 2'h0;
			fs_sync_reg <= 2'h0;
			dcl_last_reg <= 1'b0;
			fs_last_reg <= 1'b0;
			phase_reg <= 1'b0;
			frame_start_reg <= 1'b0;
			index_reg <= '0;
		end else begin
			dcl_sync_reg <= dcl_sync_next;
			fs_sync_reg <= fs_sync_next;
			dcl_last_reg <= dcl_last_next;
			fs_last_reg <= fs_last_next;
			phase_reg <= phase_next;
			frame_start_reg <= frame_start_next;
			index_reg <= index_next;
		end
	end

	assign frame_bit_clock = tick;
	assign bit_index = index_reg;

	// Helper: double-rate edges seen since the last bit tick
	logic [1:0] edge_count_reg;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			edge_count_reg <= 2'h0;
		end else if (tick) begin
			edge_count_reg <= 2'h0;
		end else if (dcl_rise && edge_count_reg != 2'h3) begin
			edge_count_reg <= edge_count_reg + 2'h1;
		end
	end

	AST_TWO_EDGES_PER_BIT: assert property (@(posedge sys_clk) disable iff (!rstn)
		tick && $past(tick) == 1'b0 && edge_count_reg != 2'h0 |-> edge_count_reg == 2'h1)
		else $error("bit tick not after two double-rate edges");
endmodule
`default_nettype wire

/* File: design/cda_sync_transfer_irq.sv */
// Overview of operation
// - Four transfer and overflow interrupt pairs share one status register.
// - Transfer irq two bit clocks after slot, port select 0; one if 1.
// - One frame bit clock equals two double-rate clock periods.
// - Enabled transfer irq: its overflow only from its own unacknowledged irq.
// - Masked transfer irq: its overflow follows any other unacknowledged one.
// - Two enabled transfer irqs: each overflow follows only its own pair.
// - No transfer irq enabled means no interrupt at all.
// - No overflow when every stimulating transfer irq was acknowledged in time.
// - Transfer irq needs the register input enabled; output alone is not enough.
// - Overflow irq needs the register output enabled; input alone is not enough.
// - Mask register holds enables for all eight interrupts.
// - Slot select picks slot 0 to 31; port select picks the data line.
`timescale 1ns/10ps
`default_nettype none
module cda_sync_transfer_irq #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic double_rate_clock,
	input wire logic frame_sync,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [cda_sync_pkg::PAIRS-1:0] port_select_bit,
	output logic irq
);
	localparam int NP = cda_sync_pkg::PAIRS;
	localparam int TW = cda_sync_pkg::TSS_W;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	generate
		if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr
			$error("ADDR_WIDTH must be 8 to 32");
		end
	endgenerate

	logic [7:0] sync_irq_status_reg, sync_irq_status_next;
	logic [7:0] sync_irq_mask_reg, sync_irq_mask_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] slot_port_config_reg [NP];
	logic [7:0] slot_port_config_next [NP];
	logic [NP-1:0] pending_reg, pending_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	logic frame_bit_clock;
	logic [cda_sync_pkg::BIT_IDX_W-1:0] bit_index;
	logic wr_take, rd_take, status_read;
	logic [NP-1:0] ack_write, xfer_en, ovf_en, in_en, out_en;
	logic [NP-1:0] xfer_hit, deadline_hit;
	logic [NP-1:0] sync_transfer_irq, miss, sync_overflow_irq;

	frame_bit_timer u_timer (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.double_rate_clock(double_rate_clock),
		.frame_sync(frame_sync),
		.frame_bit_clock(frame_bit_clock),
		.bit_index(bit_index)
	);

	function automatic logic [7:0] port_delay(input logic sel);
		return sel ? cda_sync_pkg::DELAY_PORT1 : cda_sync_pkg::DELAY_PORT0;
	endfunction

	function automatic logic [7:0] reg_offset(input logic [ADDR_WIDTH-1:0] a);
		return a[7:0];
	endfunction

	assign xfer_en = sync_irq_mask_reg[cda_sync_pkg::XFER_LSB +: NP];
	assign ovf_en = sync_irq_mask_reg[cda_sync_pkg::OVF_LSB +: NP];
	assign in_en = ctrl_reg[cda_sync_pkg::IN_EN_LSB +: NP];
	assign out_en = ctrl_reg[cda_sync_pkg::OUT_EN_LSB +: NP];

	genvar y;
	generate
		for (y = 0; y < NP; y++) begin : g_pair
			logic [TW-1:0] slot;
			logic [7:0] slot_start;
			assign slot = slot_port_config_reg[y][cda_sync_pkg::TSS_LSB +: TW];
			assign port_select_bit[y] =
				slot_port_config_reg[y][cda_sync_pkg::PORT_SEL_BIT];
			assign slot_start = {slot, 3'h0};
			// Modulo-256 wrap carries late slots into the next frame
			assign xfer_hit[y] = bit_index == slot_start +
				cda_sync_pkg::SLOT_LAST_BIT + port_delay(port_select_bit[y]);
			assign deadline_hit[y] =
				bit_index == slot_start - port_delay(port_select_bit[y]);
			assign sync_transfer_irq[y] = frame_bit_clock & xfer_hit[y] &
				xfer_en[y] & in_en[y];
			assign miss[y] = frame_bit_clock & deadline_hit[y] & pending_reg[y] &
				xfer_en[y] & in_en[y];
			// Own pair when enabled, any other pair when masked
			assign sync_overflow_irq[y] = ovf_en[y] & out_en[y] &
				(xfer_en[y] ? miss[y] : |miss);

			AST_OWN_PAIR: assert property (
				sync_overflow_irq[y] && xfer_en[y] |-> miss[y])
				else $error("overflow raised by another pair");
			AST_CROSS_PAIR: assert property (
				!xfer_en[y] && ovf_en[y] && out_en[y] && |miss
				|=> sync_irq_status_reg[cda_sync_pkg::OVF_LSB + y])
				else $error("masked pair overflow not raised");
			AST_SLOT_TIMING: assert property (
				sync_transfer_irq[y] |-> bit_index == {slot, 3'h0} +
				cda_sync_pkg::SLOT_LAST_BIT + (port_select_bit[y] ?
				cda_sync_pkg::DELAY_PORT1 : cda_sync_pkg::DELAY_PORT0))
				else $error("transfer irq at wrong bit");
		end
	endgenerate

	assign wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
	assign rd_take = s_axi_arvalid & ~rvalid_reg;
	assign status_read = rd_take &
		reg_offset(s_axi_araddr) == cda_sync_pkg::SYNC_IRQ_STATUS_OFS;
	assign ack_write = (wr_take && s_axi_wstrb[0] &&
		reg_offset(s_axi_awaddr) == cda_sync_pkg::SYNC_IRQ_ACK_OFS) ?
		s_axi_wdata[NP-1:0] : '0;

	always_comb begin
		logic [7:0] wa;
		logic [7:0] ra;
		logic hit;
		wa = reg_offset(s_axi_awaddr);
		ra = reg_offset(s_axi_araddr);
		hit = 1'b0;
		sync_irq_mask_next = sync_irq_mask_reg;
		ctrl_next = ctrl_reg;
		slot_port_config_next = slot_port_config_reg;
		bvalid_next = bvalid_reg & ~s_axi_bready;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg & ~s_axi_rready;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (wr_take) begin
			bvalid_next = 1'b1;
			bresp_next = cda_sync_pkg::RESP_OKAY;
			if (wa == cda_sync_pkg::SYNC_IRQ_MASK_OFS) begin
				if (s_axi_wstrb[0]) sync_irq_mask_next = s_axi_wdata[7:0];
			end else if (wa == cda_sync_pkg::SLOT_ACCESS_CTRL_OFS) begin
				if (s_axi_wstrb[0]) ctrl_next = s_axi_wdata[7:0];
			end else if (wa == cda_sync_pkg::SYNC_IRQ_STATUS_OFS ||
				wa == cda_sync_pkg::SYNC_IRQ_ACK_OFS) begin
				hit = 1'b1;
			end else begin
				for (int i = 0; i < NP; i++) begin
					if (wa == cda_sync_pkg::SLOT_PORT_CONFIG_OFS +
						8'(i) * cda_sync_pkg::REG_STRIDE) begin
						hit = 1'b1;
						if (s_axi_wstrb[0]) slot_port_config_next[i] = s_axi_wdata[7:0];
					end
				end
				if (!hit) bresp_next = cda_sync_pkg::RESP_SLVERR;
			end
		end
		if (rd_take) begin
			rvalid_next = 1'b1;
			rresp_next = cda_sync_pkg::RESP_OKAY;
			rdata_next = 32'h0;
			if (ra == cda_sync_pkg::SYNC_IRQ_STATUS_OFS) begin
				rdata_next[7:0] = sync_irq_status_reg;
			end else if (ra == cda_sync_pkg::SYNC_IRQ_MASK_OFS) begin
				rdata_next[7:0] = sync_irq_mask_reg;
			end else if (ra == cda_sync_pkg::SYNC_IRQ_ACK_OFS) begin
				rdata_next[NP-1:0] = pending_reg;
			end else if (ra == cda_sync_pkg::SLOT_ACCESS_CTRL_OFS) begin
				rdata_next[7:0] = ctrl_reg;
			end else begin
				hit = 1'b0;
				for (int i = 0; i < NP; i++) begin
					if (ra == cda_sync_pkg::SLOT_PORT_CONFIG_OFS +
						8'(i) * cda_sync_pkg::REG_STRIDE) begin
						hit = 1'b1;
						rdata_next[7:0] = slot_port_config_reg[i];
					end
				end
				if (!hit) rresp_next = cda_sync_pkg::RESP_SLVERR;
			end
		end
	end

	always_comb begin
		// New events win over the read-clear and the acknowledge
		sync_irq_status_next = (status_read ? 8'h00 : sync_irq_status_reg) |
			({{(8-NP){1'b0}}, sync_overflow_irq} << cda_sync_pkg::OVF_LSB) |
			({{(8-NP){1'b0}}, sync_transfer_irq} << cda_sync_pkg::XFER_LSB);
		pending_next = (pending_reg & ~ack_write & ~miss) | sync_transfer_irq;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync_irq_status_reg <= cda_sync_pkg::STATUS_RESET;
			sync_irq_mask_reg <= cda_sync_pkg::MASK_RESET;
			ctrl_reg <= cda_sync_pkg::CTRL_RESET;
			for (int i = 0; i < NP; i++) begin
				slot_port_config_reg[i] <= cda_sync_pkg::CONFIG_RESET;
			end
			pending_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= cda_sync_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= cda_sync_pkg::RESP_OKAY;
			rdata_reg <= 32'h0;
		end else begin
			sync_irq_status_reg <= sync_irq_status_next;
			sync_irq_mask_reg <= sync_irq_mask_next;
			ctrl_reg <= ctrl_next;
			slot_port_config_reg <= slot_port_config_next;
			pending_reg <= pending_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = rd_take;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	// Level output; masking also gates flags already latched
	assign irq = |(sync_irq_status_reg & sync_irq_mask_reg);

	sequence wr_accepted;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence resp_held;
		s_axi_bvalid;
	endsequence
	sequence rd_accepted;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rdata_held;
		s_axi_rvalid;
	endsequence

	AST_WRITE_RESP: assert property (wr_accepted |=> resp_held)
		else $error("write not answered next cycle");
	AST_READ_RESP: assert property (rd_accepted |=> rdata_held)
		else $error("read not answered next cycle");
	AST_MISS_CLEARS: assert property (
		miss != '0 |=>
		(pending_reg & $past(miss) & ~$past(sync_transfer_irq)) == '0)
		else $error("missed irq still pending");
	AST_NO_XFER_NO_IRQ: assert property (
		xfer_en == '0 |-> sync_transfer_irq == '0 && sync_overflow_irq == '0)
		else $error("interrupt raised with no transfer irq enabled");
	AST_ACKED_NO_OVF: assert property (
		sync_overflow_irq != '0 |-> miss != '0)
		else $error("overflow without an unacknowledged transfer irq");
	AST_INPUT_NEEDED: assert property (
		(sync_transfer_irq & ~in_en) == '0)
		else $error("transfer irq with input disabled");
	AST_OUTPUT_NEEDED: assert property (
		(sync_overflow_irq & ~out_en) == '0)
		else $error("overflow irq with output disabled");
	AST_SET_WINS: assert property (
		sync_transfer_irq != '0 |=>
		(sync_irq_status_reg[NP-1:0] & $past(sync_transfer_irq)) ==
		$past(sync_transfer_irq))
		else $error("transfer event lost");
	AST_READ_CLEARS: assert property (
		status_read && sync_transfer_irq == '0 && sync_overflow_irq == '0
		|=> sync_irq_status_reg == 8'h00 ##1 !irq || sync_irq_status_reg != 8'h00)
		else $error("status read did not clear flags");
	AST_ACK_BLOCKS_MISS: assert property (
		ack_write != '0 && sync_transfer_irq == '0 |=>
		(miss & $past(ack_write)) == '0)
		else $error("acknowledged irq reported as missed");
endmodule
`default_nettype wire

/* File: sim/test_cda_sync_transfer_irq.sv */
`timescale 1ns/10ps
`default_nettype none
module test_cda_sync_transfer_irq;
	logic sys_clk, rstn, double_rate_clock, frame_sync;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
	logic [3:0] s_axi_wstrb, port_select_bit;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [2:0] ph;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, irq;
	int errors = 0, comparisons = 0, cycles = 0, seed = 98284;
	int t00, t01, t10, s;
	logic [7:0] cm [10] = '{8'h01, 8'h10, 8'h21, 8'h31, 8'h33, 8'h23, 8'h73,
		8'h11, 8'hf3, 8'hff};
	logic [7:0] cc [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf1, 8'hff,
		8'h0f, 8'hff, 8'hff};
	bit ca [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 0};

	cda_sync_transfer_irq u_cda_sync_transfer_irq (.sys_clk, .rstn,
		.double_rate_clock, .frame_sync, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_select_bit, .irq);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Quarter-rate double-rate clock; ph[2] fixes bit phase at frame sync
	always @(posedge sys_clk) begin
		ph <= ph + 3'h1;
		double_rate_clock <= ph[1];
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 80000) begin
			errors++;
			end_sim;
		end
	end

	task automatic end_sim;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check_val(input logic [31:0] got, exp, input string what);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic check_time(input int got, exp, input string what);
		comparisons++;
		if (got != exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w, b;
		aw = 1;
		w = 1;
		b = 1;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (b) begin
			@(posedge sys_clk);
			if (s_axi_bvalid === 1'b1 && !aw && !w) begin
				rs = s_axi_bresp;
				b = 0;
			end
			if (aw && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				aw = 0;
			end
			if (w && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				w = 0;
			end
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		bit ar, r;
		ar = 1;
		r = 1;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (r) begin
			@(posedge sys_clk);
			if (s_axi_rvalid === 1'b1 && !ar) begin
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				r = 0;
			end
			if (ar && s_axi_arready === 1'b1) begin
				s_axi_arvalid <= 1'b0;
				ar = 0;
			end
		end
		s_axi_rready <= 1'b0;
	endtask

	// Without acks every enabled transfer irq is counted as missed
	function automatic logic [7:0] model(logic [7:0] m, c, bit ack);
		logic [7:0] e;
		logic [3:0] miss;
		for (int i = 0; i < 4; i++) begin
			e[i] = m[i] & c[i];
			miss[i] = e[i] & !ack;
		end
		for (int j = 0; j < 4; j++) begin
			e[4+j] = m[4+j] & c[4+j] & (m[j] ? miss[j] : |miss);
		end
		return e;
	endfunction

	task automatic run_case(input logic [7:0] m, c, input bit ack);
		logic [3:0] ps;
		logic [7:0] e;
		axi_wr(cda_sync_pkg::SYNC_IRQ_MASK_OFS, 32'h0);
		axi_wr(cda_sync_pkg::SLOT_ACCESS_CTRL_OFS, {24'h0, c});
		for (int i = 0; i < 4; i++) begin
			ps[i] = 1'($random(seed));
			axi_wr(cda_sync_pkg::SLOT_PORT_CONFIG_OFS + 8'(4 * i),
				{24'h0, ps[i], 2'b00, 5'($random(seed))});
		end
		// Stale pending from the last case must not miss under new enables
		axi_wr(cda_sync_pkg::SYNC_IRQ_ACK_OFS, 32'hf);
		axi_rd(cda_sync_pkg::SYNC_IRQ_STATUS_OFS);
		axi_wr(cda_sync_pkg::SYNC_IRQ_MASK_OFS, {24'h0, m});
		// Long enough for one event and its deadline in any slot
		repeat (48) begin
			if (ack)
				axi_wr(cda_sync_pkg::SYNC_IRQ_ACK_OFS, 32'hf);
			repeat (90) @(posedge sys_clk);
		end
		e = model(m, c, ack);
		check_val({31'h0, irq}, {31'h0, |e}, "irq level");
		axi_rd(cda_sync_pkg::SYNC_IRQ_STATUS_OFS);
		check_val(rd, {24'h0, e}, "status");
		check_val({28'h0, port_select_bit}, {28'h0, ps}, "port sel");
	endtask

	task automatic measure(input logic [4:0] sl, input logic p, output int t);
		longint t0;
		axi_wr(cda_sync_pkg::SYNC_IRQ_MASK_OFS, 32'h0);
		axi_wr(cda_sync_pkg::SLOT_PORT_CONFIG_OFS, {24'h0, p, 2'b00, sl});
		axi_rd(cda_sync_pkg::SYNC_IRQ_STATUS_OFS);
		while (ph != 3'h7) @(posedge sys_clk);
		frame_sync <= 1'b1;
		t0 = $time;
		axi_wr(cda_sync_pkg::SYNC_IRQ_MASK_OFS, 32'h1);
		frame_sync <= 1'b0;
		while (irq !== 1'b1) @(posedge sys_clk);
		t = int'(($time - t0) / 8);
		axi_rd(cda_sync_pkg::SYNC_IRQ_STATUS_OFS);
		check_val(rd, 32'h1, "timed status");
	endtask

	initial begin
		rstn = 1'b0;
		ph = 3'h0;
		double_rate_clock = 1'b0;
		frame_sync = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int a = 0; a < 32; a += 4) begin
			axi_rd(8'(a));
			check_val(rd, 32'h0, "reset value");
		end
		axi_rd(8'h20);
		check_val({rd[31:2], rs}, {30'h0, cda_sync_pkg::RESP_SLVERR}, "bad rd");
		axi_wr(8'h20, 32'hffffffff);
		check_val({30'h0, rs}, {30'h0, cda_sync_pkg::RESP_SLVERR}, "bad wr");
		axi_wr(cda_sync_pkg::SYNC_IRQ_STATUS_OFS, 32'hff);
		axi_rd(cda_sync_pkg::SYNC_IRQ_STATUS_OFS);
		check_val(rd, 32'h0, "status write ignored");
		v = $random(seed);
		axi_wr(cda_sync_pkg::SYNC_IRQ_MASK_OFS, v);
		axi_rd(cda_sync_pkg::SYNC_IRQ_MASK_OFS);
		check_val(rd, {24'h0, v[7:0]}, "mask readback");
		axi_wr(cda_sync_pkg::SLOT_ACCESS_CTRL_OFS, 32'h1);
		s = 2 + {$random(seed)} % 28;
		measure(5'(s), 1'b0, t00);
		measure(5'(s), 1'b1, t01);
		measure(5'(s + 1), 1'b0, t10);
		check_time(t00 - t01, 8, "port select delay");
		check_time(t10 - t00, 64, "slot step");
		for (int k = 0; k < 10; k++) begin
			run_case(cm[k], cc[k], ca[k]);
		end
		end_sim;
	end
endmodule
`default_nettype wire
